// ---- verilog/node_addr_pkg.sv ----
// package: constants and carrier types for the node address loader
package node_addr_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_NODE = 8'h08;
  localparam logic [7:0] ADDR_EVENT = 8'h0C;
  // ctrl fields
  localparam int CTRL_ALARM_HI_BIT = 0;
  localparam int CTRL_ALARM_LO_BIT = 1;
  localparam int CTRL_FAULT_CAL_BIT = 2;
  localparam int CTRL_FAULT_BEAM_BIT = 3;
  localparam int CTRL_PERIOD_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status fields
  localparam int STAT_VALID_BIT = 8;
  localparam int STAT_CAPTURED_BIT = 9;
  // address limits
  localparam logic [7:0] NODE_MIN = 8'h05;
  localparam logic [7:0] NODE_MAX = 8'hFA;
  // synchroniser settle count before the switches are captured
  localparam logic [1:0] SETTLE_LAST = 2'd3;
  // report periods, seconds, by system size class
  localparam int CLK_HZ = 25_000_000;
  localparam int PERIOD_S_SMALL = 1;
  localparam int PERIOD_S_MID = 2;
  localparam int PERIOD_S_LARGE = 3;
  localparam int PERIOD_CYC_SMALL = PERIOD_S_SMALL * CLK_HZ;
  localparam int PERIOD_CYC_MID = PERIOD_S_MID * CLK_HZ;
  localparam int PERIOD_CYC_LARGE = PERIOD_S_LARGE * CLK_HZ;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    KIND_ALARM,
    KIND_LEVEL,
    KIND_FAULT
  } report_kind_t;

  typedef struct packed {
    logic [7:0] node;
    report_kind_t kind;
    logic [7:0] payload;
  } report_t;
endpackage

// ---- verilog/field_node_address_capture.sv ----
// field node address capture: switch sampling, report pacing, register slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

// Function
// - address comes from eight enclosure switches
// - switch one is lsb, weights double
// - address is sum of closed switches
// - only five through 250 are valid
// - sample switches once at power up
// - new setting needs full power cycle
// - no conflict check; duplicates still report
// - alarms immediate; level and fault periodic
module field_node_address_capture
  import node_addr_pkg::*;
  #(
    parameter int PERIOD_SMALL = PERIOD_CYC_SMALL,
    parameter int PERIOD_MID = PERIOD_CYC_MID,
    parameter int PERIOD_LARGE = PERIOD_CYC_LARGE
  ) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // switch bank, closed = 1
  input wire logic [7:0] addr_sw,
  // gas level sample from the sensing core
  input wire logic [7:0] gas_level,
  // report channel to the network interface
  output logic report_valid,
  input wire logic report_ready,
  output report_t report,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic node_ok(input logic [7:0] a);
    node_ok = (a >= NODE_MIN) && (a <= NODE_MAX);
  endfunction

  // switch synchroniser
  logic [7:0] sw_meta_ff;
  logic [7:0] sw_sync_ff;
  always_ff @(posedge sys_clk) begin
    sw_meta_ff <= addr_sw;
    sw_sync_ff <= sw_meta_ff;
  end

  // capture once, after the synchroniser has settled following reset;
  // srst stands for power-up, so only a fresh reset re-reads the switches
  logic [1:0] settle_ff;
  logic captured_ff;
  logic [7:0] node_ff;
  logic valid_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      settle_ff <= 2'd0;
      captured_ff <= 1'b0;
      node_ff <= 8'h00;
      valid_ff <= 1'b0;
    end else if (!captured_ff) begin
      if (settle_ff != SETTLE_LAST) begin
        settle_ff <= settle_ff + 2'd1;
      end else begin
        captured_ff <= 1'b1;
        // bit i carries weight 2**i, so the sum of closed weights is the word
        node_ff <= sw_sync_ff;
        valid_ff <= node_ok(sw_sync_ff);
      end
    end
  end

  // control register
  logic [31:0] ctrl_ff;
  logic [1:0] alarm_q_ff;
  logic [1:0] fault_q_ff;

  // pending immediate alarm event on any alarm bit change
  logic alarm_pend_ff;
  logic alarm_evt;
  logic [1:0] alarm_now;
  assign alarm_now = {ctrl_ff[CTRL_ALARM_LO_BIT], ctrl_ff[CTRL_ALARM_HI_BIT]};
  assign alarm_evt = (alarm_now != alarm_q_ff);

  // period timer for level and fault reports
  logic [31:0] tick_ff;
  logic [31:0] period;
  logic tick_hit;
  always_comb begin
    case (ctrl_ff[CTRL_PERIOD_LSB +: 2])
      2'd0: period = 32'(PERIOD_SMALL);
      2'd1: period = 32'(PERIOD_MID);
      default: period = 32'(PERIOD_LARGE);
    endcase
  end
  assign tick_hit = (tick_ff >= period - 32'd1);

  // timer idles while the node is invalid, so a refused address never reports
  always_ff @(posedge sys_clk) begin
    if (srst || !valid_ff || tick_hit) begin
      tick_ff <= 32'h0000_0000;
    end else begin
      tick_ff <= tick_ff + 32'd1;
    end
  end

  logic periodic_pend_ff;
  logic send_level_ff;

  // report sequencer: alarms pre-empt periodic reports
  typedef enum logic [1:0] {S_IDLE, S_SEND} rep_state_t;
  rep_state_t rep_state_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm_q_ff <= 2'b00;
      alarm_pend_ff <= 1'b0;
    end else begin
      alarm_q_ff <= alarm_now;
      // set wins over clear so an alarm change in the idle cycle that launches the pending alarm report is not lost
      if (alarm_evt && valid_ff) begin
        alarm_pend_ff <= 1'b1;
      end else if (rep_state_ff == S_IDLE && alarm_pend_ff) begin
        alarm_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      periodic_pend_ff <= 1'b0;
    end else if (tick_hit && valid_ff) begin
      periodic_pend_ff <= 1'b1;
    end else if (rep_state_ff == S_IDLE && !alarm_pend_ff && periodic_pend_ff
                 && !send_level_ff) begin
      periodic_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rep_state_ff <= S_IDLE;
      report_valid <= 1'b0;
      report <= '0;
      send_level_ff <= 1'b0;
      fault_q_ff <= 2'b00;
    end else begin
      case (rep_state_ff)
        S_IDLE: begin
          // duplicates are not detected; always report under own node
          if (alarm_pend_ff) begin
            report <= '{node: node_ff, kind: KIND_ALARM,
                        payload: {6'd0, alarm_now}};
            report_valid <= 1'b1;
            rep_state_ff <= S_SEND;
          end else if (periodic_pend_ff && !send_level_ff) begin
            report <= '{node: node_ff, kind: KIND_LEVEL, payload: gas_level};
            report_valid <= 1'b1;
            send_level_ff <= 1'b1;
            rep_state_ff <= S_SEND;
          end else if (send_level_ff) begin
            // fault follows its level report, both on one period tick
            fault_q_ff <= {ctrl_ff[CTRL_FAULT_BEAM_BIT], ctrl_ff[CTRL_FAULT_CAL_BIT]};
            report <= '{node: node_ff, kind: KIND_FAULT,
                        payload: {6'd0, ctrl_ff[CTRL_FAULT_BEAM_BIT],
                                  ctrl_ff[CTRL_FAULT_CAL_BIT]}};
            report_valid <= 1'b1;
            send_level_ff <= 1'b0;
            rep_state_ff <= S_SEND;
          end
        end
        S_SEND: begin
          if (report_ready) begin
            report_valid <= 1'b0;
            rep_state_ff <= S_IDLE;
          end
        end
        default: rep_state_ff <= S_IDLE;
      endcase
    end
  end

  // event counter: reports accepted by the network side
  // wraps silently; software compares two reads
  logic [15:0] sent_cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sent_cnt_ff <= 16'h0000;
    end else if (report_valid && report_ready) begin
      sent_cnt_ff <= sent_cnt_ff + 16'd1;
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;
  // response waits for both halves; the next pair is taken only after bready
  assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      // readies pulse every other cycle while idle; a held valid waits one edge
      s_axi_awready <= !aw_have_ff && !s_axi_awready;
      s_axi_wready <= !w_have_ff && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_ff == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (do_write && aw_addr_ff == ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_ff[b]) begin
          ctrl_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
        end
      end
    end
  end

  // axi4-lite read path
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      // unmapped offsets answer slverr with zero data
      case (s_axi_araddr)
        ADDR_CTRL: s_axi_rdata <= ctrl_ff;
        ADDR_STATUS: s_axi_rdata <= {22'd0, captured_ff, valid_ff, node_ff};
        ADDR_NODE: s_axi_rdata <= {24'd0, node_ff};
        ADDR_EVENT: s_axi_rdata <= {12'd0, fault_q_ff, alarm_q_ff, sent_cnt_ff};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // field_node_address_capture

// ---- dv/fnac_monitor.sv ----
// checker: report channel and read answer rules
`timescale 1ns/1ps
module fnac_monitor
  import node_addr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // switches and report channel
  input wire logic [7:0] addr_sw,
  input wire logic report_valid,
  input wire logic report_ready,
  input wire report_t report,
  // read answer
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  logic [7:0] sw_ff;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // only power-up may load the switches
  always_ff @(posedge sys_clk) begin
    if (srst) sw_ff <= addr_sw;
  end
  a_report_hold: assert property (
    report_valid && !report_ready |=> report_valid && $stable(report))
    else $error("report not held");
  a_report_drop: assert property (
    report_valid && report_ready |=> !report_valid)
    else $error("report kept after take");
  a_node_range: assert property (
    report_valid |-> report.node >= NODE_MIN && report.node <= NODE_MAX)
    else $error("report from invalid node");
  a_node_sum: assert property (
    report_valid |-> report.node == sw_ff)
    else $error("report node not switch value");
  a_quiet_start: assert property (
    $fell(srst) |-> !report_valid [*4])
    else $error("report before capture");
  a_kind_legal: assert property (
    report_valid |-> report.kind inside {KIND_ALARM, KIND_LEVEL, KIND_FAULT})
    else $error("bad report kind");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
endmodule // fnac_monitor

// ---- dv/net_ctrl_model.sv ----
// network controller model: takes reports, latches alarms and faults
`timescale 1ns/1ps
module net_ctrl_model
  import node_addr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // report channel
  input wire logic report_valid,
  input wire report_t report,
  output logic report_ready,
  // stall control and seen state
  input wire logic slow,
  output int n_alm,
  output int n_lvl,
  output logic [7:0] lvl_pay,
  output logic [1:0] alm_latch,
  output logic [1:0] flt_latch
);
  always_ff @(posedge sys_clk) begin
    report_ready <= slow ? 1'($urandom) : 1'b1;
    if (srst) begin
      n_alm <= 0;
      n_lvl <= 0;
      alm_latch <= 2'h0;
      flt_latch <= 2'h0;
    end else if (report_valid && report_ready && report.node >= NODE_MIN
        && report.node <= NODE_MAX) begin
      // newest level report wins, alarm and fault bits accumulate; only the node range is checked
      case (report.kind)
        KIND_ALARM: begin
          n_alm <= n_alm + 1;
          alm_latch <= alm_latch | report.payload[1:0];
        end
        KIND_LEVEL: begin
          n_lvl <= n_lvl + 1;
          lvl_pay <= report.payload;
        end
        default: flt_latch <= flt_latch | report.payload[1:0];
      endcase
    end
  end
endmodule // net_ctrl_model

// ---- dv/field_node_address_capture_tb_top.sv ----
// testbench: switch capture, reports, register access
`timescale 1ns/1ps
module field_node_address_capture_tb_top;
  import node_addr_pkg::*;
  localparam int PS = 40;
  logic sys_clk, srst, slow, report_valid, report_ready;
  logic [7:0] addr_sw, gas_level, s_axi_awaddr, s_axi_araddr, lvl_pay;
  report_t report;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, alm_latch, flt_latch;
  logic [33:0] exp_q[$];
  int n_alm, n_lvl, error_cnt, n_checks;

  field_node_address_capture #(.PERIOD_SMALL(PS), .PERIOD_MID(2 * PS),
    .PERIOD_LARGE(3 * PS)) i_field_node_address_capture (
    .sys_clk, .srst, .addr_sw, .gas_level, .report_valid, .report_ready, .report,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  net_ctrl_model i_net_ctrl_model (.sys_clk, .srst, .report_valid, .report,
    .report_ready, .slow, .n_alm, .n_lvl, .lvl_pay, .alm_latch, .flt_latch);

  function automatic logic ok(input logic [7:0] n);
    return n >= NODE_MIN && n <= NODE_MAX;
  endfunction
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic power(input logic [7:0] sw);
    @(posedge sys_clk);
    srst <= 1'b1;
    addr_sw <= sw;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // cycles between two level reports with the far side always ready
  task automatic gap(input logic [31:0] c, input int p);
    int m, t;
    wr(ADDR_CTRL, c, RESP_OKAY);
    m = n_lvl;
    t = 0;
    while (n_lvl == m) @(posedge sys_clk);
    m = n_lvl;
    while (n_lvl == m) begin
      @(posedge sys_clk);
      t++;
    end
    chk("level gap", 34'(t), 34'(p));
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk("write", {s_axi_bresp, 32'h0}, exp_q.pop_front());
  end
  initial begin
    logic [7:0] sws [7];
    int k;
    {srst, slow, addr_sw, gas_level} = {1'b1, 1'b0, 16'h0000};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    void'($urandom(94));
    // edges of the valid range, reserved and out of range
    sws = '{8'h05, 8'hFA, 8'h00, 8'h04, 8'hFB, 8'hFF, 8'h00};
    sws[6] = 8'(5 + $urandom % 246);
    foreach (sws[i]) begin
      power(sws[i]);
      rd(ADDR_STATUS, {24'h0, 1'b1, ok(sws[i]), sws[i]});
      rd(ADDR_NODE, {26'h0, sws[i]});
      k = n_alm;
      wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
      repeat (6) @(posedge sys_clk);
      chk("alarm count", 34'(n_alm - k), 34'(ok(sws[i])));
      chk("alarm latch", 34'(alm_latch), 34'(ok(sws[i])));
    end
    $display("test address done");
    power(8'h2A);
    addr_sw <= 8'h07;
    repeat (10) @(posedge sys_clk);
    rd(ADDR_NODE, {26'h0, 8'h2A});
    wr(ADDR_NODE, 32'h0000_00FF, RESP_SLVERR);
    rd(8'h10, {RESP_SLVERR, 32'h0});
    power(8'h07);
    rd(ADDR_NODE, {26'h0, 8'h07});
    $display("test power cycle done");
    // far side stalls while level reports keep coming
    slow <= 1'b1;
    gas_level <= 8'($urandom);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    k = n_lvl;
    repeat (3 * PS) @(posedge sys_clk);
    chk("level count", 34'((n_lvl - k) >= 2), 34'h1);
    chk("level data", 34'(lvl_pay), 34'(gas_level));
    $display("test periodic done");
    // every period select, fault bits and the low alarm
    slow <= 1'b0;
    gap(32'h0000_0000, PS);
    gap(32'h0000_001C, 2 * PS);
    chk("fault latch", 34'(flt_latch), 34'h3);
    gap(32'h0000_0020, 3 * PS);
    gap(32'h0000_0030, 3 * PS);
    wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
    repeat (6) @(posedge sys_clk);
    chk("low alarm latch", 34'(alm_latch), 34'h2);
    $display("test period select done");
    wrap_up();
  end
endmodule // field_node_address_capture_tb_top

bind field_node_address_capture fnac_monitor i_fnac_monitor (.sys_clk, .srst, .addr_sw,
  .report_valid, .report_ready, .report, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp);
